// *** pdf_host.sv ***
// Host end: fetches the descriptor, then probes or writes the status
`timescale 1ns/1ps
`include "pdf_regs.svh"
module pdf_host #(
	parameter int ADDR_BYTES = 3
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Link to the device
	pdf_link_if.host link
);

	localparam logic [5:0] ALEN = 6'(ADDR_BYTES * 8);

	if (ADDR_BYTES != 1 && ADDR_BYTES != 3 && ADDR_BYTES != 4)
		$error("pdf_host: ADDR_BYTES must be 1, 3 or 4");

	pdf_pkg::pdf_host_t s_q;
	pdf_pkg::pdf_host_t s_d;
	logic [3:0] dcount;
	logic [7:0] op;
	logic [31:0] a32;
	logic unusable;
	logic go;
	pdf_pkg::pdf_lane_t nmode;

	// Enter the data phase after opcode, address or dummies
	function automatic pdf_pkg::pdf_host_t host_data(
		input pdf_pkg::pdf_host_t v
	);
		pdf_pkg::pdf_host_t r;
		r = v;
		r.cnt = 6'h00;
		if (v.kind == pdf_pkg::HK_WRITE)
		begin
			r.st = pdf_pkg::HS_WR;
			r.sh = {v.wbyte, 24'h000000};
		end
		else
		begin
			r.st = pdf_pkg::HS_RD;
			r.len = `PDF_BYTE_BITS;
		end
		return r;
	endfunction

	assign nmode = pdf_pkg::pdf_lane_t'(reg_wdata[`PDF_C_MODE]);
	assign go = reg_wr && reg_addr == `PDF_REG_CTRL;
	assign op = reg_wdata[`PDF_C_WRITE] ? s_q.desc[`PDF_F_WROP] :
		s_q.desc[`PDF_F_RDOP];
	assign dcount = (s_q.mode == pdf_pkg::LM_111) ? 4'h0 :
		s_q.desc[`PDF_F_DUMMY]; // RULE10 RULE11
	// Local address placed in byte 0 or byte 1, then left aligned
	assign a32 = (s_q.desc[`PDF_B_BYTE1] ?
		{16'h0000, s_q.desc[`PDF_F_LADDR], 8'h00} :
		{24'h000000, s_q.desc[`PDF_F_LADDR]}) << (6'h20 - ALEN); // RULE8

	// A cleared mode flag leaves the dummy count unknown, not the mode
	// missing, so such a request is refused rather than reported absent
	always_comb
	begin
		unusable = !s_q.desc_ok || !s_q.desc[`PDF_B_AVAIL] || // RULE16
			op == 8'h00 || nmode > pdf_pkg::LM_8D8D8D; // RULE13 RULE14
		if (!s_q.desc[`PDF_B_ADDRD] && nmode != pdf_pkg::LM_111 &&
			nmode <= pdf_pkg::LM_8D8D8D &&
			!s_q.desc[`PDF_F_MODES][2'(nmode - 3'h1)])
			unusable = 1'b1; // RULE12
	end

	// Next-state logic, one link bit per cycle
	always_comb
	begin
		s_d = s_q;
		s_d.strobe = 1'b0;
		s_d.rdstb = 1'b0;
		s_d.pend = s_q.rdstb;
		s_d.rdata = 32'h0;
		// Register reads answer in the next cycle
		if (reg_rd)
		begin
			case (reg_addr)
				`PDF_REG_CTRL: s_d.rdata = {25'h0, s_q.mode, 4'h0};
				`PDF_REG_STATUS: s_d.rdata = {27'h0, s_q.done,
					s_q.refused, s_q.asleep, s_q.desc_ok,
					s_q.st != pdf_pkg::HS_IDLE};
				`PDF_REG_DESC: s_d.rdata = s_q.desc;
				default: s_d.rdata = 32'h0;
			endcase
		end
		case (s_q.st)
			pdf_pkg::HS_IDLE:
			begin
				if (go && |reg_wdata[2:0])
				begin
					s_d.done = 1'b0;
					s_d.refused = 1'b0;
					s_d.mode = nmode;
					s_d.wbyte = reg_wdata[`PDF_C_WDATA];
					s_d.cnt = 6'h00;
					if (reg_wdata[`PDF_C_FETCH])
					begin
						s_d.kind = pdf_pkg::HK_FETCH;
						s_d.sh = {`PDF_DESC_OP, 24'h000000};
						s_d.st = pdf_pkg::HS_OPC;
						s_d.sel = 1'b1;
					end
					else if (unusable)
					begin
						s_d.refused = 1'b1; // RULE13 RULE14 RULE16
						s_d.done = 1'b1;
					end
					else
					begin
						s_d.kind = reg_wdata[`PDF_C_WRITE] ?
							pdf_pkg::HK_WRITE : pdf_pkg::HK_PROBE;
						s_d.sh = {op, 24'h000000}; // RULE15
						s_d.st = pdf_pkg::HS_OPC;
						s_d.sel = 1'b1;
					end
				end
			end
			pdf_pkg::HS_OPC, pdf_pkg::HS_ADDR, pdf_pkg::HS_WR:
			begin
				s_d.mosi = s_q.sh[31];
				s_d.strobe = 1'b1;
				s_d.sh = {s_q.sh[30:0], 1'b0};
				s_d.cnt = s_q.cnt + 6'h01;
				if (s_q.st == pdf_pkg::HS_OPC &&
					s_q.cnt == `PDF_OP_BITS - 6'h01)
				begin
					s_d.cnt = 6'h00;
					if (s_q.kind == pdf_pkg::HK_FETCH)
					begin
						s_d.st = pdf_pkg::HS_RD;
						s_d.len = `PDF_DESC_BITS;
					end
					else if (s_q.desc[`PDF_B_ADDRD])
					begin
						s_d.st = pdf_pkg::HS_ADDR; // RULE8
						s_d.sh = a32;
					end
					else if (dcount == 4'h0)
						s_d = host_data(s_d); // RULE11
					else
						s_d.st = pdf_pkg::HS_DUMMY;
				end
				else if (s_q.st == pdf_pkg::HS_ADDR &&
					s_q.cnt == ALEN - 6'h01)
					s_d = host_data(s_d);
				else if (s_q.st == pdf_pkg::HS_WR &&
					s_q.cnt == `PDF_BYTE_BITS - 6'h01)
					s_d.st = pdf_pkg::HS_DONE;
			end
			pdf_pkg::HS_DUMMY:
			begin
				s_d.mosi = 1'b0;
				s_d.strobe = 1'b1;
				s_d.cnt = s_q.cnt + 6'h01;
				if (s_q.cnt == 6'(dcount) - 6'h01)
					s_d = host_data(s_d); // RULE10
			end
			pdf_pkg::HS_RD:
			begin
				// Device answers one cycle after it sees each strobe
				if (s_q.cnt < s_q.len)
				begin
					s_d.strobe = 1'b1;
					s_d.rdstb = 1'b1;
					s_d.mosi = 1'b0;
					s_d.cnt = s_q.cnt + 6'h01;
				end
				if (s_q.pend)
					s_d.sh = {s_q.sh[30:0], link.miso};
				else if (s_q.cnt == s_q.len && !s_q.rdstb)
					s_d.st = pdf_pkg::HS_DONE;
			end
			pdf_pkg::HS_DONE:
			begin
				s_d.sel = 1'b0;
				s_d.done = 1'b1;
				s_d.st = pdf_pkg::HS_IDLE;
				if (s_q.kind == pdf_pkg::HK_FETCH)
				begin
					s_d.desc = s_q.sh;
					s_d.desc_ok = 1'b1;
				end
				else if (s_q.kind == pdf_pkg::HK_PROBE)
					// Asleep when the flag reads the same as the polarity bit
					s_d.asleep = s_q.desc[`PDF_B_POL] ~^
						s_q.sh[s_q.desc[`PDF_F_POS]]; // RULE15 RULE2
			end
			default:
				s_d.st = pdf_pkg::HS_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			s_q <= `PDF_RST_VAL;
		else
			s_q <= s_d;
	end

	assign reg_rdata = s_q.rdata;
	assign link.sel = s_q.sel;
	assign link.mosi = s_q.mosi;
	assign link.strobe = s_q.strobe;
	assign link.mode = s_q.mode;

endmodule

// *** pdf_regs.svh ***
// Constants for the power-down flag descriptor link: fields, offsets, resets
//
// Summary of operation
// [RULE1] Bit 31 set when status bit exists
// [RULE2] Bit 30 gives status bit polarity
// [RULE3] Bit 29 reserved, always zero
// [RULE4] Bit 28 set for addressed access
// [RULE5] Bit 27 set when address in byte 1
// [RULE6] Byte 1 placement never with 8-bit addressing
// [RULE7] Bits 26-24 give flag bit position
// [RULE8] Addressed: bits 23-16 hold local address
// [RULE9] Direct: bits 23-20 flag supported lane modes
// [RULE10] Bits 19-16 dummy count, host inserts it
// [RULE11] Single-lane mode uses zero dummy cycles
// [RULE12] Cleared mode flag does not mean absent
// [RULE13] Bits 15-8 read opcode, zero means none
// [RULE14] Bits 7-0 write opcode, zero means none
// [RULE15] Host reads register, extracts flag, applies polarity
// [RULE16] Host ignores fields when bit 31 clear
`ifndef PDF_REGS_SVH
`define PDF_REGS_SVH

// Descriptor word layout
`define PDF_B_AVAIL 31
`define PDF_B_POL 30
`define PDF_B_RSVD 29
`define PDF_B_ADDRD 28
`define PDF_B_BYTE1 27
`define PDF_F_POS 26:24
`define PDF_F_LADDR 23:16
`define PDF_F_MODES 23:20
`define PDF_F_DUMMY 19:16
`define PDF_F_RDOP 15:8
`define PDF_F_WROP 7:0

// Opcode that returns the descriptor word itself
`define PDF_DESC_OP 8'h5a

// Host register offsets
`define PDF_REG_CTRL 4'h0
`define PDF_REG_STATUS 4'h4
`define PDF_REG_DESC 4'h8

// Host control register fields
`define PDF_C_FETCH 0
`define PDF_C_PROBE 1
`define PDF_C_WRITE 2
`define PDF_C_MODE 6:4
`define PDF_C_WDATA 15:8

// Lengths and reset values
`define PDF_OP_BITS 6'h08
`define PDF_DESC_BITS 6'h20
`define PDF_BYTE_BITS 6'h08
`define PDF_RST_VAL '0

`endif

// *** pdf_pkg.sv ***
// Types shared by both ends of the descriptor link
package pdf_pkg;

	typedef enum logic [2:0] {
		LM_111 = 3'h0,
		LM_4S4S4S = 3'h1,
		LM_4S4D4D = 3'h2,
		LM_8S8S8S = 3'h3,
		LM_8D8D8D = 3'h4
	} pdf_lane_t;

	typedef enum logic [2:0] {
		DS_CMD = 3'h0,
		DS_ADDR = 3'h1,
		DS_DUMMY = 3'h2,
		DS_RD = 3'h3,
		DS_WR = 3'h4,
		DS_SKIP = 3'h5
	} pdf_dev_state_t;

	typedef enum logic [2:0] {
		HS_IDLE = 3'h0,
		HS_OPC = 3'h1,
		HS_ADDR = 3'h2,
		HS_DUMMY = 3'h3,
		HS_RD = 3'h4,
		HS_WR = 3'h5,
		HS_DONE = 3'h6
	} pdf_host_state_t;

	typedef enum logic [1:0] {
		HK_FETCH = 2'h0,
		HK_PROBE = 2'h1,
		HK_WRITE = 2'h2
	} pdf_kind_t;

	typedef struct packed {
		pdf_dev_state_t st;
		logic [7:0] op;
		logic [5:0] cnt;
		logic [31:0] sh;
		logic hit;
		logic miso;
		logic [7:0] ctl;
	} pdf_dev_t;

	typedef struct packed {
		pdf_host_state_t st;
		pdf_kind_t kind;
		pdf_lane_t mode;
		logic [5:0] cnt;
		logic [5:0] len;
		logic [31:0] sh;
		logic [31:0] desc;
		logic [7:0] wbyte;
		logic desc_ok;
		logic asleep;
		logic refused;
		logic done;
		logic sel;
		logic mosi;
		logic strobe;
		logic rdstb;
		logic pend;
		logic [31:0] rdata;
	} pdf_host_t;

endpackage

// *** pdf_link_if.sv ***
// Serial link between the memory device and its host controller
`timescale 1ns/1ps
interface pdf_link_if;
	logic sel;
	logic mosi;
	logic strobe;
	pdf_pkg::pdf_lane_t mode;
	logic miso;

	modport dev (
		input sel,
		input mosi,
		input strobe,
		input mode,
		output miso
	);

	modport host (
		output sel,
		output mosi,
		output strobe,
		output mode,
		input miso
	);
endinterface

// *** pdf_dev.sv ***
// Device end: serves the descriptor word and the status register
`timescale 1ns/1ps
`include "pdf_regs.svh"
module pdf_dev #(
	parameter bit AVAIL = 1'b1,
	parameter bit POLARITY = 1'b0,
	parameter bit ADDRESSED = 1'b0,
	parameter bit BYTE1 = 1'b0,
	parameter logic [2:0] BITPOS = 3'h0,
	parameter logic [7:0] LOCAL_ADDR = 8'h00,
	parameter logic [3:0] MODES = 4'h1,
	parameter logic [3:0] DUMMY = 4'h8,
	parameter logic [7:0] RD_OP = 8'h65,
	parameter logic [7:0] WR_OP = 8'h71,
	parameter int ADDR_BYTES = 3
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Link to the host
	pdf_link_if.dev link,
	// User side
	input wire logic sleep_in,
	output logic [7:0] ctl_out
);

	localparam logic [5:0] ALEN = 6'(ADDR_BYTES * 8);

	// Refuse settings the descriptor cannot describe
	if (ADDR_BYTES != 1 && ADDR_BYTES != 3 && ADDR_BYTES != 4)
		$error("pdf_dev: ADDR_BYTES must be 1, 3 or 4");
	if (BYTE1 && ADDR_BYTES == 1)
		$error("pdf_dev: byte 1 placement needs 24 or 32-bit address"); // RULE6
	if (RD_OP == `PDF_DESC_OP || WR_OP == `PDF_DESC_OP)
		$error("pdf_dev: opcode clashes with descriptor opcode");
	if (RD_OP == WR_OP && RD_OP != 8'h00)
		$error("pdf_dev: read and write opcodes must differ");

	pdf_pkg::pdf_dev_t s_q;
	pdf_pkg::pdf_dev_t s_d;
	logic [7:0] stat;
	logic [7:0] rx_byte;
	logic [3:0] dcount;
	logic mode_ok;

	// Assemble the read-only descriptor word from the build parameters
	function automatic logic [31:0] desc_word();
		logic [31:0] w;
		w = 32'h0;
		w[`PDF_B_AVAIL] = AVAIL; // RULE1
		w[`PDF_B_POL] = POLARITY; // RULE2
		w[`PDF_B_RSVD] = 1'b0; // RULE3
		w[`PDF_B_ADDRD] = ADDRESSED; // RULE4
		w[`PDF_B_BYTE1] = BYTE1; // RULE5
		w[`PDF_F_POS] = BITPOS; // RULE7
		if (ADDRESSED)
			w[`PDF_F_LADDR] = LOCAL_ADDR; // RULE8
		else
		begin
			w[`PDF_F_MODES] = MODES; // RULE9
			w[`PDF_F_DUMMY] = DUMMY; // RULE10
		end
		w[`PDF_F_RDOP] = RD_OP; // RULE13
		w[`PDF_F_WROP] = WR_OP; // RULE14
		return w;
	endfunction

	// Step from the opcode, address or dummy phase into the data phase
	function automatic pdf_pkg::pdf_dev_t enter_data(
		input pdf_pkg::pdf_dev_t v,
		input logic [7:0] st_byte
	);
		pdf_pkg::pdf_dev_t r;
		r = v;
		r.cnt = 6'h00;
		if (v.op == WR_OP)
			r.st = pdf_pkg::DS_WR; // RULE14
		else
		begin
			r.st = pdf_pkg::DS_RD; // RULE13
			// A miss on the local address reads back as zero
			r.sh = {(v.hit ? st_byte : 8'h00), 24'h000000};
		end
		return r;
	endfunction

	// Status byte: stored control bits with the live flag inserted
	always_comb
	begin
		stat = s_q.ctl;
		stat[BITPOS] = POLARITY ? sleep_in : ~sleep_in; // RULE2
	end

	assign rx_byte = {s_q.sh[6:0], link.mosi};
	// Single lane always runs without dummy cycles
	assign dcount = (link.mode == pdf_pkg::LM_111) ? 4'h0 : DUMMY; // RULE11
	// Multi-lane direct access only in the modes this part flags
	assign mode_ok = (link.mode == pdf_pkg::LM_111) ||
		(link.mode <= pdf_pkg::LM_8D8D8D &&
		MODES[2'(link.mode - 3'h1)]); // RULE9

	// Next-state logic, one bit per host strobe
	always_comb
	begin
		s_d = s_q;
		if (!link.sel)
		begin
			// Deselect ends any frame, whatever phase it was in
			s_d.st = pdf_pkg::DS_CMD;
			s_d.cnt = 6'h00;
			s_d.miso = 1'b0;
		end
		else if (link.strobe)
		begin
			case (s_q.st)
				pdf_pkg::DS_CMD:
				begin
					s_d.sh = {s_q.sh[30:0], link.mosi};
					s_d.cnt = s_q.cnt + 6'h01;
					if (s_q.cnt == `PDF_OP_BITS - 6'h01)
					begin
						s_d.op = rx_byte;
						s_d.cnt = 6'h00;
						s_d.hit = 1'b1;
						if (rx_byte == `PDF_DESC_OP)
						begin
							s_d.st = pdf_pkg::DS_RD;
							s_d.sh = desc_word();
						end
						else if (AVAIL && rx_byte != 8'h00 &&
							(rx_byte == RD_OP || rx_byte == WR_OP))
						begin
							if (ADDRESSED)
								s_d.st = pdf_pkg::DS_ADDR; // RULE4
							else if (!mode_ok)
								s_d.st = pdf_pkg::DS_SKIP;
							else if (dcount == 4'h0)
								s_d = enter_data(s_d, stat); // RULE11
							else
								s_d.st = pdf_pkg::DS_DUMMY; // RULE10
						end
						else
							s_d.st = pdf_pkg::DS_SKIP;
					end
				end
				pdf_pkg::DS_ADDR:
				begin
					s_d.sh = {s_q.sh[30:0], link.mosi};
					s_d.cnt = s_q.cnt + 6'h01;
					if (s_q.cnt == ALEN - 6'h01)
					begin
						// Local address sits in byte 0 or byte 1
						s_d.hit = (BYTE1 ? s_d.sh[15:8] : s_d.sh[7:0]) ==
							LOCAL_ADDR; // RULE5 RULE8
						s_d = enter_data(s_d, stat);
					end
				end
				pdf_pkg::DS_DUMMY:
				begin
					s_d.cnt = s_q.cnt + 6'h01;
					if (s_q.cnt == 6'(dcount) - 6'h01)
						s_d = enter_data(s_d, stat); // RULE10
				end
				pdf_pkg::DS_RD:
				begin
					// Past the word end the line reads zero
					s_d.miso = s_q.sh[31];
					s_d.sh = {s_q.sh[30:0], 1'b0};
				end
				pdf_pkg::DS_WR:
				begin
					s_d.sh = {s_q.sh[30:0], link.mosi};
					s_d.cnt = s_q.cnt + 6'h01;
					if (s_q.cnt == `PDF_BYTE_BITS - 6'h01)
					begin
						if (s_q.hit)
							s_d.ctl = rx_byte; // RULE14
						s_d.st = pdf_pkg::DS_SKIP;
					end
				end
				pdf_pkg::DS_SKIP:
					s_d.miso = 1'b0;
				default:
					s_d.st = pdf_pkg::DS_SKIP;
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			s_q <= `PDF_RST_VAL;
		else
			s_q <= s_d;
	end

	assign link.miso = s_q.miso;
	assign ctl_out = s_q.ctl;

endmodule

// *** pdf_link_props.sv ***
// Checker for the serial link between descriptor host and device
`timescale 1ns/1ps
`include "pdf_regs.svh"
module pdf_link_props #(
	parameter logic [7:0] RD_OP = 8'h65,
	parameter logic [7:0] WR_OP = 8'h71,
	parameter logic [3:0] MODES = 4'h1,
	parameter logic [3:0] DUMMY = 4'h8,
	// Word served by a device built with its default parameters
	parameter logic [31:0] DESC = 32'h8018_6571
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Link signals
	input wire logic sel,
	input wire logic mosi,
	input wire logic strobe,
	input wire pdf_pkg::pdf_lane_t mode,
	input wire logic miso
);
	logic [6:0] cnt_q;
	logic [7:0] op_q;
	logic rd_q;
	logic [31:0] sh_q;
	logic [4:0] flags;
	logic lane_ok;
	logic is_acc;
	logic [6:0] acc_len;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Strobes in the current frame; restarts whenever select drops
	always_ff @(posedge sys_clk)
	begin
		if (rst || !sel)
			cnt_q <= 7'h00;
		else if (strobe)
			cnt_q <= cnt_q + 7'h01;
	end

	// Opcode, and returned bits one cycle behind their strobe
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			op_q <= 8'h00;
			rd_q <= 1'b0;
			sh_q <= 32'h0;
		end
		else
		begin
			if (sel && strobe && cnt_q < 7'h08)
				op_q <= {op_q[6:0], mosi};
			rd_q <= sel && strobe && cnt_q >= 7'h08;
			if (rd_q)
				sh_q <= {sh_q[30:0], miso};
		end
	end

	// Single lane always allowed and never waits
	assign flags = {MODES, 1'b1};
	assign lane_ok = (mode <= pdf_pkg::LM_8D8D8D) && flags[mode];
	assign is_acc = (op_q == RD_OP) || (op_q == WR_OP);
	assign acc_len = (mode == pdf_pkg::LM_111) ? 7'h10 : 7'h10 + {3'h0, DUMMY};

	sequence frame_end;
		$fell(sel);
	endsequence

	sequence opcode_in;
		sel && cnt_q == 7'h08;
	endsequence

	strobe_in_frame_a: assert property (strobe |-> sel)
		else $error("strobe outside a frame");
	opcode_nonzero_a: assert property (opcode_in |-> op_q != 8'h00)
		else $error("null opcode sent");
	desc_length_a: assert property (frame_end ##0 op_q == `PDF_DESC_OP |-> cnt_q == 7'h28)
		else $error("descriptor frame length wrong");
	desc_value_a: assert property (frame_end ##0 op_q == `PDF_DESC_OP |-> sh_q == DESC)
		else $error("descriptor word wrong on the wire");
	access_len_a: assert property (frame_end ##0 is_acc |-> cnt_q == acc_len)
		else $error("status access frame length wrong");
	lane_flag_a: assert property (opcode_in ##0 is_acc |-> lane_ok)
		else $error("status access in an unflagged mode");
	mode_steady_a: assert property (sel && $past(sel) |-> $stable(mode))
		else $error("mode changed inside a frame");
	miso_idle_a: assert property (!sel && !$past(sel) |-> !miso)
		else $error("read line active between frames");
endmodule

// *** test_power_down_flag_descriptor.sv ***
// Self-checking bench driving both host and device ends of the link
`timescale 1ns/1ps
`include "pdf_regs.svh"
module test_power_down_flag_descriptor;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic sleep_in = 1'b0;
	logic [3:0] reg_addr[2] = '{4'h0, 4'h0};
	logic [31:0] reg_wdata[2] = '{32'h0, 32'h0};
	logic reg_wr[2] = '{1'b0, 1'b0};
	logic reg_rd[2] = '{1'b0, 1'b0};
	logic [31:0] reg_rdata[2];
	logic [7:0] ctl_out[2];
	int bad_count = 0;
	int checks_done = 0;

	pdf_link_if link0();
	pdf_link_if link1();

	// Direct access, dummy 8, only 4S-4S-4S flagged
	pdf_dev pdf_dev_inst (.sys_clk(sys_clk), .rst(rst), .link(link0),
		.sleep_in(sleep_in), .ctl_out(ctl_out[0]));
	pdf_host pdf_host_inst (.sys_clk(sys_clk), .rst(rst),
		.reg_addr(reg_addr[0]), .reg_wdata(reg_wdata[0]), .reg_wr(reg_wr[0]),
		.reg_rd(reg_rd[0]), .reg_rdata(reg_rdata[0]), .link(link0));
	// Addressed, byte 1 placement, inverted polarity, flag at bit 5
	pdf_dev #(.POLARITY(1'b1), .ADDRESSED(1'b1), .BYTE1(1'b1), .BITPOS(3'h5),
		.LOCAL_ADDR(8'h3c)) pdf_dev_b_inst (.sys_clk(sys_clk),
		.rst(rst), .link(link1), .sleep_in(sleep_in), .ctl_out(ctl_out[1]));
	pdf_host pdf_host_b_inst (.sys_clk(sys_clk), .rst(rst),
		.reg_addr(reg_addr[1]), .reg_wdata(reg_wdata[1]), .reg_wr(reg_wr[1]),
		.reg_rd(reg_rd[1]), .reg_rdata(reg_rdata[1]), .link(link1));
	pdf_link_props pdf_link_props_inst (
		.sys_clk(sys_clk), .rst(rst), .sel(link0.sel), .mosi(link0.mosi),
		.strobe(link0.strobe), .mode(link0.mode), .miso(link0.miso));

	always #10 sys_clk = ~sys_clk;

	task check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task wr(input int h, input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr[h] <= a;
		reg_wdata[h] <= d;
		reg_wr[h] <= 1'b1;
		@(posedge sys_clk);
		reg_wr[h] <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task rd(input int h, input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr[h] <= a;
		reg_rd[h] <= 1'b1;
		@(posedge sys_clk);
		reg_rd[h] <= 1'b0;
		#1 d = reg_rdata[h];
	endtask

	// Issue a command, poll until idle under a bound, compare status
	task cmd(input int h, input logic [31:0] c, input logic [31:0] exp);
		logic [31:0] s;
		int n;
		wr(h, `PDF_REG_CTRL, c);
		s = 32'h1;
		n = 0;
		while (s[0] !== 1'b0 && n < 200)
		begin
			rd(h, `PDF_REG_STATUS, s);
			n++;
		end
		check("status", s, exp);
	endtask

	task conclude;
		$display("checks_done %0d bad_count %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles the run needs
	initial
	begin
		#200us;
		bad_count++;
		conclude();
	end

	initial
	begin
		logic [31:0] v;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		rd(0, `PDF_REG_DESC, v);
		check("desc reset", v, 32'h0);
		rd(0, 4'hc, v);
		check("unmapped", v, 32'h0);
		cmd(0, 32'h2, 32'h18);
		cmd(0, 32'h1, 32'h12);
		rd(0, `PDF_REG_DESC, v);
		check("desc direct", v, 32'h8018_6571);
		// Unflagged and unknown modes first, while asleep is still clear
		sleep_in <= 1'b1;
		for (int m = 5; m >= 0; m--)
		begin
			cmd(0, {25'h0, m[2:0], 4'h2},
				(m < 2) ? 32'h16 : 32'h1a);
			rd(0, `PDF_REG_CTRL, v);
			check("ctrl mode", v, {25'h0, m[2:0], 4'h0});
		end
		sleep_in <= 1'b0;
		cmd(0, 32'h2, 32'h12);
		cmd(0, 32'ha604, 32'h12);
		check("ctl single", {24'h0, ctl_out[0] & 8'hfe}, 32'ha6);
		cmd(0, 32'hb714, 32'h12);
		check("ctl quad", {24'h0, ctl_out[0] & 8'hfe}, 32'hb6);
		cmd(0, 32'hc134, 32'h1a);
		check("ctl kept", {24'h0, ctl_out[0] & 8'hfe}, 32'hb6);
		// Addressed device: mode flags do not apply
		cmd(1, 32'h1, 32'h12);
		rd(1, `PDF_REG_DESC, v);
		check("desc addressed", v, 32'hdd3c_6571);
		sleep_in <= 1'b1;
		cmd(1, 32'h32, 32'h16);
		sleep_in <= 1'b0;
		cmd(1, 32'h2, 32'h12);
		cmd(1, 32'hc304, 32'h12);
		check("ctl addressed", {24'h0, ctl_out[1] & 8'hdf}, 32'hc3);
		// A command written while busy is dropped
		sleep_in <= 1'b1;
		wr(0, `PDF_REG_CTRL, 32'h1);
		cmd(0, 32'h2, 32'h12);
		conclude();
	end
endmodule
